// file: tb_top.sv
// self-checking bench for the test-mode access control block
`timescale 1ns/1ps
module tb_top;
  import tmac_pkg::*;
  typedef struct {logic [11:0] a; tmac_tgt_t t; logic [1:0] s; logic [3:0] i;} tmac_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, rd_en, wr_dir, mode, data_oe, outputs_oe, normal_sel, normal_wr, normal_rd;
  logic isbt, factory_mode, sub_wr, sub_rd;
  logic [11:0] addr;
  logic [7:0] data_in, data_out, forced, func_data_out, sub_wdata;
  logic [7:0] sensed = 8'h3C;
  logic [7:0] func_in = 8'hC3;
  logic [7:0] normal_rdata = 8'h96;
  logic [7:0] sub_rdata = 8'h69;
  tmac_tgt_t sub_tgt;
  logic [1:0] sub_slice;
  logic [3:0] sub_index;
  int failures = 0;
  int compares = 0;
  tmac_row_t rows [17];
  logic [11:0] st_a [3] = '{12'h820, 12'h905, 12'hC02};
  tmac_tgt_t st_t [3] = '{TMAC_TGT_PP, TMAC_TGT_POH, TMAC_TGT_TB};

  always #5 sys_clk = ~sys_clk;

  tmac_host i_tmac_host (.sys_clk(sys_clk), .chip_select_low(cs_n),
    .read_or_enable_input(rd_en), .write_or_direction_input(wr_dir),
    .bus_mode_select(mode), .addr(addr), .data_in(data_in));
  tmac_top i_tmac_top (.sys_clk(sys_clk), .rst(rst), .chip_select_low(cs_n),
    .read_or_enable_input(rd_en), .write_or_direction_input(wr_dir),
    .bus_mode_select(mode), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .sensed_input_byte(sensed), .forced_output_byte(forced),
    .outputs_oe(outputs_oe), .normal_sel(normal_sel), .normal_wr(normal_wr),
    .normal_rd(normal_rd), .normal_rdata(normal_rdata), .func_data_out(func_data_out),
    .func_data_in(func_in), .internal_sub_block_test(isbt), .factory_mode(factory_mode),
    .sub_tgt(sub_tgt), .sub_slice(sub_slice), .sub_index(sub_index), .sub_wr(sub_wr),
    .sub_rd(sub_rd), .sub_wdata(sub_wdata), .sub_rdata(sub_rdata));

  task automatic test_done();
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_tmac_host.start(1'b0, a, d);
    i_tmac_host.stop();
  endtask
  // unused bits masked off before compare
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
                    input logic oe);
    i_tmac_host.start(1'b1, a, 8'h00);
    if (oe)
      chk(data_out & m, e);
    chk(8'(data_oe), 8'(oe));
    chk(8'(normal_rd), 8'(!a[11]));
    chk(8'(sub_rd), 8'(a == 12'h905));
    i_tmac_host.stop();
  endtask
  task automatic steer(input logic [11:0] a, input tmac_tgt_t t, input logic [1:0] s,
                       input logic [3:0] i);
    i_tmac_host.start(1'b0, a, 8'h5A);
    chk(8'(sub_wr), 8'(t != TMAC_TGT_NONE));
    chk(8'(normal_wr), 8'(!a[11]));
    chk(8'(normal_sel), 8'(!a[11]));
    if (!a[11])
      chk(func_data_out, 8'h5A);
    if (t != TMAC_TGT_NONE)
    begin
      chk(8'(sub_tgt), 8'(t));
      chk(sub_wdata, 8'h5A);
      chk(8'(sub_slice), 8'(s));
      chk(8'(sub_index), 8'(i));
    end
    i_tmac_host.stop();
  endtask

  initial
  begin
    #100000;
    failures++;
    test_done();
  end

  initial
  begin
    rows = '{'{12'h820, TMAC_TGT_PP, 2'h1, 4'h0}, '{12'h822, TMAC_TGT_PP, 2'h1, 4'h4},
      '{12'h8A1, TMAC_TGT_PP, 2'h1, 4'h3}, '{12'h840, TMAC_TGT_PP, 2'h2, 4'h0},
      '{12'h8C2, TMAC_TGT_PP, 2'h2, 4'h5}, '{12'h862, TMAC_TGT_PP, 2'h3, 4'h4},
      '{12'h8E0, TMAC_TGT_PP, 2'h3, 4'h1}, '{12'h900, TMAC_TGT_POH, 2'h1, 4'h0},
      '{12'hA0F, TMAC_TGT_POH, 2'h2, 4'hF}, '{12'hB05, TMAC_TGT_POH, 2'h3, 4'h5},
      '{12'hC00, TMAC_TGT_TB, 2'h1, 4'h0}, '{12'hC43, TMAC_TGT_TB, 2'h2, 4'h3},
      '{12'hC83, TMAC_TGT_TB, 2'h3, 4'h3}, '{12'hC84, TMAC_TGT_NONE, 2'h0, 4'h0},
      '{12'h823, TMAC_TGT_NONE, 2'h0, 4'h0}, '{12'h910, TMAC_TGT_NONE, 2'h0, 4'h0},
      '{12'h123, TMAC_TGT_NONE, 2'h0, 4'h0}};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(8'(outputs_oe), 8'h01);
    chk(8'(isbt), 8'h00);
    rd(12'h800, 8'h05, 8'h00, 1'b1);
    foreach (rows[k])
      steer(rows[k].a, rows[k].t, rows[k].s, rows[k].i);
    rd(12'h123, 8'hFF, 8'h96, 1'b1);
    rd(12'h905, 8'hFF, 8'h69, 1'b1);
    rd(12'hC84, 8'hFF, 8'h00, 1'b1);
    // pin test: refused, then forced output and sensed input
    wr(12'h801, 8'h5A);
    chk(forced, 8'hC3);
    wr(12'h800, 8'h04);
    chk(8'(isbt), 8'h01);
    rd(12'h800, 8'h05, 8'h04, 1'b1);
    wr(12'h801, 8'hA5);
    chk(forced, 8'hA5);
    rd(12'h801, 8'hFF, 8'h3C, 1'b1);
    wr(12'h800, 8'h20);
    rd(12'h800, 8'h05, 8'h00, 1'b1);
    chk(forced, 8'hC3);
    // output float keeps the bus alive, data float removes read data
    wr(12'h800, 8'h01);
    chk(8'(outputs_oe), 8'h00);
    rd(12'h800, 8'h05, 8'h01, 1'b1);
    wr(12'h800, 8'h03);
    rd(12'h800, 8'h05, 8'h00, 1'b0);
    wr(12'h800, 8'h00);
    chk(8'(outputs_oe), 8'h01);
    i_tmac_host.pins_low();
    chk(8'(outputs_oe), 8'h00);
    chk(8'(data_oe), 8'h00);
    i_tmac_host.stop();
    // alternate decode bit lets enable/direction decode run with chip select high
    wr(12'h800, 8'h08);
    i_tmac_host.set_mode(1'b0);
    i_tmac_host.cs_keep_high = 1'b1;
    steer(12'h123, TMAC_TGT_NONE, 2'h0, 4'h0);
    rd(12'h123, 8'hFF, 8'h96, 1'b1);
    i_tmac_host.cs_keep_high = 1'b0;
    i_tmac_host.set_mode(1'b1);
    // factory mode: survives writes, slice steering, cleared by chip select
    wr(12'h800, 8'h10);
    chk(8'(factory_mode), 8'h01);
    chk(8'(isbt), 8'h01);
    wr(12'h800, 8'h00);
    chk(8'(factory_mode), 8'h01);
    for (int s = 1; s < 4; s++)
    begin
      wr(12'h800, {s[1:0], 6'h10});
      steer(st_a[s - 1], st_t[s - 1], s[1:0], st_a[s - 1][3:0]);
    end
    wr(12'h800, 8'h10);
    steer(12'h8C1, TMAC_TGT_PP, 2'h2, 4'h3);
    wr(12'h800, 8'h90);
    i_tmac_host.cs_high();
    #1;
    chk(8'(factory_mode), 8'h00);
    wr(12'h800, 8'h10);
    steer(12'h820, TMAC_TGT_PP, 2'h1, 4'h0);
    test_done();
  end
endmodule

// file: tmac_checker.sv
// concurrent checks on the ports of the test-mode access control block
`timescale 1ns/1ps
module tmac_checker
  import tmac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host port
  input wire logic chip_select_low,
  input wire logic read_or_enable_input,
  input wire logic write_or_direction_input,
  input wire logic bus_mode_select,
  input wire logic [11:0] addr,
  input wire logic [7:0] data_in,
  input wire logic data_oe,
  // pins and steering
  input wire logic outputs_oe,
  input wire logic normal_wr,
  input wire logic internal_sub_block_test,
  input wire logic factory_mode,
  input wire tmac_pkg::tmac_tgt_t sub_tgt,
  input wire logic [1:0] sub_slice,
  input wire logic [3:0] sub_index,
  input wire logic sub_wr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // first edge of a write to the master test register
  sequence s_wr_master;
    bus_mode_select && !chip_select_low && read_or_enable_input &&
      $fell(write_or_direction_input) && addr == ADDR_MASTER_TEST;
  endsequence
  sequence s_float_set;
    s_wr_master ##0 data_in[MT_FLOAT_OUTPUTS];
  endsequence
  sequence s_pin_set;
    s_wr_master ##0 data_in[MT_PIN_TEST];
  endsequence

  float_out_a: assert property (s_float_set |-> ##2 !outputs_oe)
    else $error("outputs still driven after float write");
  pin_mode_a: assert property (s_pin_set |-> ##2 internal_sub_block_test)
    else $error("sub-blocks not in test mode after pin test write");
  board_float_a: assert property (!chip_select_low && !read_or_enable_input &&
    !write_or_direction_input && bus_mode_select |=> !outputs_oe && !data_oe)
    else $error("board float did not release the pins");
  normal_space_a: assert property (normal_wr |-> !addr[TEST_SPACE_BIT])
    else $error("normal write with test space address");
  test_space_a: assert property (sub_wr |-> addr[TEST_SPACE_BIT])
    else $error("sub-block write with normal space address");
  pp_decode_a: assert property (sub_wr && sub_tgt == TMAC_TGT_PP |->
    addr[11:8] == 4'h8 && sub_index < 4'h6 && sub_slice != 2'h0)
    else $error("payload decode out of range");
  poh_decode_a: assert property (sub_wr && sub_tgt == TMAC_TGT_POH |->
    addr[11:8] inside {4'h9, 4'hA, 4'hB} && addr[7:4] == 4'h0 && sub_index == addr[3:0])
    else $error("overhead decode out of range");
  tb_decode_a: assert property (sub_wr && sub_tgt == TMAC_TGT_TB |->
    addr[11:8] == 4'hC && sub_index == {2'h0, addr[1:0]})
    else $error("trace buffer decode out of range");
  factory_hold_a: assert property (!chip_select_low [*2] ##0 factory_mode |=> factory_mode)
    else $error("factory mode lost with chip select low");
  factory_clear_a: assert property (chip_select_low [*2] |=> !factory_mode)
    else $error("factory mode kept with chip select high");
  factory_or_a: assert property (factory_mode |-> ##[0:1] internal_sub_block_test)
    else $error("factory mode without sub-block test mode");
  reset_out_a: assert property ($fell(rst) |-> !data_oe && !sub_wr && !normal_wr &&
    !factory_mode && !internal_sub_block_test && sub_tgt == TMAC_TGT_NONE)
    else $error("outputs not cleared by reset");
endmodule

bind tmac_top tmac_checker i_chk (.sys_clk(sys_clk), .rst(rst),
  .chip_select_low(chip_select_low), .read_or_enable_input(read_or_enable_input),
  .write_or_direction_input(write_or_direction_input), .bus_mode_select(bus_mode_select),
  .addr(addr), .data_in(data_in), .data_oe(data_oe), .outputs_oe(outputs_oe),
  .normal_wr(normal_wr), .internal_sub_block_test(internal_sub_block_test),
  .factory_mode(factory_mode), .sub_tgt(sub_tgt), .sub_slice(sub_slice),
  .sub_index(sub_index), .sub_wr(sub_wr));

// file: tmac_host.sv
// host processor model on the parallel register port
`timescale 1ns/1ps
module tmac_host
(
  // clock
  input wire logic sys_clk,
  // port pins
  output logic chip_select_low,
  output logic read_or_enable_input,
  output logic write_or_direction_input,
  output logic bus_mode_select,
  output logic [11:0] addr,
  output logic [7:0] data_in
);
  // high lets an access run without chip select
  logic cs_keep_high = 1'b0;
  initial
  begin
    chip_select_low = 1'b1;
    read_or_enable_input = 1'b1;
    write_or_direction_input = 1'b1;
    bus_mode_select = 1'b1;
    addr = 12'h000;
    data_in = 8'h00;
  end
  // strobe held until stop; direction level equals rd in both modes
  task automatic start(input logic rd, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    chip_select_low <= cs_keep_high;
    read_or_enable_input <= bus_mode_select ? !rd : 1'b1;
    write_or_direction_input <= rd;
    addr <= a;
    data_in <= d;
    @(posedge sys_clk);
    #1;
  endtask
  // chip select stays low so factory state survives between accesses
  task automatic stop();
    @(posedge sys_clk);
    read_or_enable_input <= bus_mode_select;
    write_or_direction_input <= 1'b1;
    data_in <= ~data_in;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic cs_high();
    @(posedge sys_clk);
    chip_select_low <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic pins_low();
    @(posedge sys_clk);
    chip_select_low <= 1'b0;
    read_or_enable_input <= 1'b0;
    write_or_direction_input <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic set_mode(input logic m);
    @(posedge sys_clk);
    bus_mode_select <= m;
    read_or_enable_input <= m;
  endtask
endmodule

// file: tmac_pkg.sv
// constants and types for the test-mode access control block
package tmac_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // address map
  localparam logic [11:0] TEST_SPACE_BIT_MASK = 12'h800;
  localparam int TEST_SPACE_BIT = 11;
  localparam logic [11:0] ADDR_MASTER_TEST = 12'h800;
  localparam logic [11:0] ADDR_PIN_TEST_BYTE = 12'h801;
  localparam logic [11:0] PP_LO_BASE_1 = 12'h820;
  localparam logic [11:0] PP_HI_BASE_1 = 12'h8A0;
  localparam logic [11:0] PP_SLICE_STEP = 12'h020;
  localparam logic [11:0] PP_REG_COUNT = 12'h003;
  localparam logic [11:0] POH_BASE_1 = 12'h900;
  localparam logic [11:0] POH_SLICE_STEP = 12'h100;
  localparam logic [11:0] POH_REG_COUNT = 12'h010;
  localparam logic [11:0] TB_BASE_1 = 12'hC00;
  localparam logic [11:0] TB_SLICE_STEP = 12'h040;
  localparam logic [11:0] TB_REG_COUNT = 12'h004;
  // master test register fields
  localparam int MT_FLOAT_OUTPUTS = 0;
  localparam int MT_FLOAT_DATA = 1;
  localparam int MT_PIN_TEST = 2;
  localparam int MT_ALT_DECODE = 3;
  localparam int MT_FACTORY = 4;
  localparam int MT_SSEL_LO = 6;
  localparam int MT_SSEL_HI = 7;
  localparam logic [7:0] MT_RESET = 8'h00;
  localparam logic [7:0] MT_READ_MASK = 8'h05;
  localparam logic [1:0] SSEL_DIRECT = 2'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // target kinds of the sub-block decoder
  typedef enum logic [1:0] {
    TMAC_TGT_NONE = 2'h0,
    TMAC_TGT_PP = 2'h1,
    TMAC_TGT_POH = 2'h3,
    TMAC_TGT_TB = 2'h2
  } tmac_tgt_t;

  // bus cycle sequencer states, gray along idle-active-hold
  typedef enum logic [1:0] {
    TMAC_BUS_IDLE = 2'h0,
    TMAC_BUS_ACTIVE = 2'h1,
    TMAC_BUS_HOLD = 2'h3
  } tmac_bus_state_t;
endpackage

// file: tmac_slice_decode.sv
// sub-block and slice decoder for the test register space
`timescale 1ns/1ps
module tmac_slice_decode
  import tmac_pkg::*;
(
  // access
  input wire logic [11:0] addr,
  input wire logic factory_test_enable,
  input wire logic [1:0] ssel,
  // decode result
  output tmac_pkg::tmac_tgt_t tgt,
  output logic [1:0] slice,
  output logic [3:0] reg_index
);
  logic [11:0] off;

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] base,
                                    input logic [11:0] cnt);
    in_range = (a >= base) && (a < 12'(base + cnt));
  endfunction

  always_comb
  begin
    tgt = TMAC_TGT_NONE;
    slice = 2'h0;
    reg_index = 4'h0;
    off = 12'h000;
    if (factory_test_enable && ssel != SSEL_DIRECT)
    begin
      // slice-one range picks the block kind, ssel picks the slice
      slice = ssel;
      if (in_range(addr, PP_LO_BASE_1, PP_REG_COUNT))
      begin
        tgt = TMAC_TGT_PP;
        reg_index = 4'(addr - PP_LO_BASE_1) << 1;
      end
      else if (in_range(addr, PP_HI_BASE_1, PP_REG_COUNT))
      begin
        tgt = TMAC_TGT_PP;
        reg_index = 4'((addr - PP_HI_BASE_1) << 1) | 4'h1;
      end
      else if (in_range(addr, POH_BASE_1, POH_REG_COUNT))
      begin
        tgt = TMAC_TGT_POH;
        reg_index = 4'(addr - POH_BASE_1);
      end
      else if (in_range(addr, TB_BASE_1, TB_REG_COUNT))
      begin
        tgt = TMAC_TGT_TB;
        reg_index = 4'(addr - TB_BASE_1);
      end
    end
    else
    begin
      // full address selects directly
      for (int s = 0; s < 3; s++)
      begin
        off = 12'(s) * PP_SLICE_STEP;
        if (in_range(addr, 12'(PP_LO_BASE_1 + off), PP_REG_COUNT))
        begin
          tgt = TMAC_TGT_PP;
          slice = 2'(s + 1);
          reg_index = 4'(addr - 12'(PP_LO_BASE_1 + off)) << 1;
        end
        if (in_range(addr, 12'(PP_HI_BASE_1 + off), PP_REG_COUNT))
        begin
          tgt = TMAC_TGT_PP;
          slice = 2'(s + 1);
          reg_index = 4'((addr - 12'(PP_HI_BASE_1 + off)) << 1) | 4'h1;
        end
        off = 12'(s) * POH_SLICE_STEP;
        if (in_range(addr, 12'(POH_BASE_1 + off), POH_REG_COUNT))
        begin
          tgt = TMAC_TGT_POH;
          slice = 2'(s + 1);
          reg_index = 4'(addr - 12'(POH_BASE_1 + off));
        end
        off = 12'(s) * TB_SLICE_STEP;
        // C84H upward stays unmatched
        if (in_range(addr, 12'(TB_BASE_1 + off), TB_REG_COUNT))
        begin
          tgt = TMAC_TGT_TB;
          slice = 2'(s + 1);
          reg_index = 4'(addr - 12'(TB_BASE_1 + off));
        end
      end
    end
  end
endmodule

// file: tmac_strobe_decode.sv
// bus strobe decode for both bus modes
`timescale 1ns/1ps
module tmac_strobe_decode
(
  // pins
  input wire logic chip_select_low,
  input wire logic read_or_enable_input,
  input wire logic write_or_direction_input,
  input wire logic bus_mode_select,
  input wire logic alt_bus_decode_test,
  // decoded
  output logic rd_act,
  output logic wr_act,
  output logic board_float
);
  logic cs;

  always_comb
  begin
    cs = !chip_select_low;
    // all three low in separate-strobe mode floats the pins
    board_float = bus_mode_select && !chip_select_low && !read_or_enable_input
                  && !write_or_direction_input;
    if (bus_mode_select)
    begin
      rd_act = cs && !read_or_enable_input && write_or_direction_input;
      wr_act = cs && !write_or_direction_input && read_or_enable_input;
    end
    else
    begin
      // enable/direction decode; test bit lets it run without chip select
      rd_act = (cs || alt_bus_decode_test) && read_or_enable_input
               && write_or_direction_input;
      wr_act = (cs || alt_bus_decode_test) && read_or_enable_input
               && !write_or_direction_input;
    end
  end
endmodule

// file: tmac_top.sv
// test-mode access control: master test register, pin test and sub-block steering
// Function
// - CS, read and write strobes low with bus mode high float all pins.
// - Address bit 11 high selects test space, low selects normal space.
// - Payload slices decode test regs 0/2/4 at low base, 1/3/5 at high base.
// - Overhead slices expose sixteen test registers at 900H, A00H, B00H.
// - Trace buffer slices expose four registers at C00H, C40H, C80H.
// - Unused test bits ignore writes; their reads may be either level.
// - Writable test bits need no reset unless stated.
// - Reset clears master test register except factory test enable.
// - Output float bit tri-states all outputs but data bus; bus works.
// - Data float bit also tri-states the data bus.
// - Pin test holds sub-blocks in test mode; test writes drive outputs.
// - Alternate decode test exercises enable/direction decode when bus mode low.
// - Factory test bit makes port the vector port, ORed with pin test.
// - Factory test bit clears only when chip select goes high.
// - Factory test with slice select zero decodes full address directly.
// - Slice select 1,2,3 steers slice-one range accesses to that slice.
// - Slice select clears whenever chip select is high.
// - Pin test lets host read inputs and force outputs.
// - Pin test write to 801H forces the parallel output byte.
// - Pin test read of 801H returns the parallel input byte.

`timescale 1ns/1ps
module tmac_top
  import tmac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host parallel port
  input wire logic chip_select_low,
  input wire logic read_or_enable_input,
  input wire logic write_or_direction_input,
  input wire logic bus_mode_select,
  input wire logic [11:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // pins sensed and forced in pin test
  input wire logic [7:0] sensed_input_byte,
  output logic [7:0] forced_output_byte,
  output logic outputs_oe,
  // normal register space
  output logic normal_sel,
  output logic normal_wr,
  output logic normal_rd,
  input wire logic [7:0] normal_rdata,
  output logic [7:0] func_data_out,
  input wire logic [7:0] func_data_in,
  // sub-block test access
  output logic internal_sub_block_test,
  output logic factory_mode,
  output tmac_pkg::tmac_tgt_t sub_tgt,
  output logic [1:0] sub_slice,
  output logic [3:0] sub_index,
  output logic sub_wr,
  output logic sub_rd,
  output logic [7:0] sub_wdata,
  input wire logic [7:0] sub_rdata
);
  import tmac_pkg::*;

  typedef struct packed {
    // access sequencer
    tmac_bus_state_t st;

    // master test bits
    logic [1:0] ssel;
    logic factory_test_enable;
    logic alt_bus_decode_test;
    logic pin_test_enable;
    logic float_data_bus;
    logic float_outputs;

    // pin test byte, left unreset
    logic [7:0] pin_byte;

    // host data bus
    logic [7:0] data_out;
    logic data_oe;

    // pin drivers
    logic [7:0] forced_output_byte;
    logic outputs_oe;

    // normal register space
    logic normal_sel;
    logic normal_wr;
    logic normal_rd;
    logic [7:0] func_data_out;

    // sub-block test access
    logic sub_test;
    logic factory_mode;
    tmac_tgt_t sub_tgt;
    logic [1:0] sub_slice;
    logic [3:0] sub_index;
    logic sub_wr;
    logic sub_rd;
    logic [7:0] sub_wdata;
  } tmac_state_t;

  tmac_state_t state_ff;
  tmac_state_t nxt_state;
  // strobe decode results
  logic rd_act;
  logic wr_act;
  logic board_float;

  // sub-block decode results
  tmac_tgt_t dec_tgt;
  logic [1:0] dec_slice;
  logic [3:0] dec_index;

  // read path
  logic test_space;
  logic [7:0] rd_byte;

  // both bus modes end in one read and one write strobe
  tmac_strobe_decode u_strobe
  (
    .chip_select_low(chip_select_low),
    .read_or_enable_input(read_or_enable_input),
    .write_or_direction_input(write_or_direction_input),
    .bus_mode_select(bus_mode_select),
    .alt_bus_decode_test(state_ff.alt_bus_decode_test),
    .rd_act(rd_act),
    .wr_act(wr_act),
    .board_float(board_float)
  );

  // decodes every cycle; the sequencer picks when to use it
  tmac_slice_decode u_slice
  (
    .addr(addr),
    .factory_test_enable(state_ff.factory_test_enable),
    .ssel(state_ff.ssel),
    .tgt(dec_tgt),
    .slice(dec_slice),
    .reg_index(dec_index)
  );

  // exact match against one test register
  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  always_comb
  begin
    nxt_state = state_ff;
    // bit 11 splits normal and test space
    test_space = addr[TEST_SPACE_BIT];
    // undecoded test space reads give zero
    rd_byte = UNMAPPED_READ;
    // access strobes are one-cycle pulses
    nxt_state.normal_wr = 1'b0;
    nxt_state.normal_rd = 1'b0;
    nxt_state.sub_wr = 1'b0;
    nxt_state.sub_rd = 1'b0;

    // one access per strobe assertion: act on entry, wait for release
    unique case (state_ff.st)
      TMAC_BUS_IDLE:
      begin
        if (rd_act || wr_act)
          nxt_state.st = TMAC_BUS_ACTIVE;
      end
      TMAC_BUS_ACTIVE:
      begin
        nxt_state.st = TMAC_BUS_HOLD;
      end
      TMAC_BUS_HOLD:
      begin
        if (!rd_act && !wr_act)
          nxt_state.st = TMAC_BUS_IDLE;
      end
      // code 2 is unused; recover to idle
      default:
      begin
        nxt_state.st = TMAC_BUS_IDLE;
      end
    endcase

    // writes are taken once, on entry to the access
    if (state_ff.st == TMAC_BUS_IDLE && wr_act)
    begin
      if (!test_space)
      begin
        nxt_state.normal_sel = 1'b1;
        nxt_state.normal_wr = 1'b1;
        nxt_state.func_data_out = data_in;
      end
      else if (is_addr(addr, ADDR_MASTER_TEST))
      begin
        // bit 5 is unused, so it is never stored
        nxt_state.float_outputs = data_in[MT_FLOAT_OUTPUTS];
        nxt_state.float_data_bus = data_in[MT_FLOAT_DATA];
        nxt_state.pin_test_enable = data_in[MT_PIN_TEST];
        nxt_state.alt_bus_decode_test = data_in[MT_ALT_DECODE];
        // a write can set but never clear factory
        nxt_state.factory_test_enable = state_ff.factory_test_enable
                                        | data_in[MT_FACTORY];
        nxt_state.ssel = data_in[MT_SSEL_HI:MT_SSEL_LO];
      end
      else if (is_addr(addr, ADDR_PIN_TEST_BYTE) && state_ff.pin_test_enable)
      begin
        // refused outside pin test; old byte kept
        nxt_state.pin_byte = data_in;
      end
      else if (dec_tgt != TMAC_TGT_NONE)
      begin
        // test mode 0 writes reach the sub-block outputs
        nxt_state.sub_wr = 1'b1;
        nxt_state.sub_wdata = data_in;
      end
    end

    // read pulses only; the byte comes from the live mux
    if (state_ff.st == TMAC_BUS_IDLE && rd_act)
    begin
      if (!test_space)
      begin
        nxt_state.normal_sel = 1'b1;
        nxt_state.normal_rd = 1'b1;
      end
      else if (dec_tgt != TMAC_TGT_NONE)
        nxt_state.sub_rd = 1'b1;
    end

    // normal select drops once the strobes are gone
    if (state_ff.st == TMAC_BUS_IDLE && !rd_act && !wr_act)
      nxt_state.normal_sel = 1'b0;

    // target stays latched until another decoded address
    if (dec_tgt != TMAC_TGT_NONE && state_ff.st == TMAC_BUS_IDLE)
    begin
      nxt_state.sub_tgt = dec_tgt;
      nxt_state.sub_slice = dec_slice;
      nxt_state.sub_index = dec_index;
    end

    // read data mux, sampled live while the read strobe is held
    if (!test_space)
      rd_byte = normal_rdata;
    // only the two read/write master bits show
    else if (is_addr(addr, ADDR_MASTER_TEST))
      rd_byte = {4'h0, state_ff.float_data_bus, state_ff.pin_test_enable,
                 1'b0, state_ff.float_outputs} & MT_READ_MASK;
    else if (is_addr(addr, ADDR_PIN_TEST_BYTE) && state_ff.pin_test_enable)
      rd_byte = sensed_input_byte;
    else if (dec_tgt != TMAC_TGT_NONE)
      rd_byte = sub_rdata;
    // zero between reads so no stale byte leaks out
    nxt_state.data_out = rd_act ? rd_byte : BYTE_ZERO;

    // data bus floats for board test or the data float bit
    nxt_state.data_oe = rd_act && !board_float && !state_ff.float_data_bus;
    // outputs float on board test or the output float bit; bus keeps running
    nxt_state.outputs_oe = !board_float && !state_ff.float_outputs;
    // pin test forces the parallel output byte
    nxt_state.forced_output_byte = state_ff.pin_test_enable ? state_ff.pin_byte
                                   : func_data_in;
    // factory test counts as pin test for the sub-blocks
    nxt_state.sub_test = state_ff.pin_test_enable | state_ff.factory_test_enable;
    nxt_state.factory_mode = state_ff.factory_test_enable;

    // chip select high clears factory test and slice select
    // placed after the write decode so the clear wins a tie
    if (chip_select_low)
    begin
      nxt_state.factory_test_enable = 1'b0;
      nxt_state.ssel = SSEL_DIRECT;
    end

    if (rst)
    begin
      // pin_byte stays unreset on purpose; it is only written in pin
      // factory test is left to chip select
      nxt_state.st = TMAC_BUS_IDLE;
      nxt_state.float_outputs = MT_RESET[MT_FLOAT_OUTPUTS];
      nxt_state.float_data_bus = MT_RESET[MT_FLOAT_DATA];
      nxt_state.pin_test_enable = MT_RESET[MT_PIN_TEST];
      nxt_state.alt_bus_decode_test = MT_RESET[MT_ALT_DECODE];
      nxt_state.ssel = MT_RESET[MT_SSEL_HI:MT_SSEL_LO];
      nxt_state.data_out = BYTE_ZERO;
      nxt_state.data_oe = 1'b0;
      nxt_state.forced_output_byte = BYTE_ZERO;
      nxt_state.outputs_oe = 1'b0;
      nxt_state.normal_sel = 1'b0;
      nxt_state.normal_wr = 1'b0;
      nxt_state.normal_rd = 1'b0;
      nxt_state.func_data_out = BYTE_ZERO;
      nxt_state.sub_test = 1'b0;
      nxt_state.factory_mode = 1'b0;
      nxt_state.sub_tgt = TMAC_TGT_NONE;
      nxt_state.sub_slice = 2'h0;
      nxt_state.sub_index = 4'h0;
      nxt_state.sub_wr = 1'b0;
      nxt_state.sub_rd = 1'b0;
      nxt_state.sub_wdata = BYTE_ZERO;
    end
  end

  // one register stage; reset arrives through nxt_state
  always_ff @(posedge sys_clk)
  begin
    state_ff <= nxt_state;
  end

  // host data bus
  assign data_out = state_ff.data_out;
  assign data_oe = state_ff.data_oe;

  // pin drivers
  assign forced_output_byte = state_ff.forced_output_byte;
  assign outputs_oe = state_ff.outputs_oe;

  // normal register space
  assign normal_sel = state_ff.normal_sel;
  assign normal_wr = state_ff.normal_wr;
  assign normal_rd = state_ff.normal_rd;
  assign func_data_out = state_ff.func_data_out;

  // sub-block test access
  assign internal_sub_block_test = state_ff.sub_test;
  assign factory_mode = state_ff.factory_mode;
  assign sub_tgt = state_ff.sub_tgt;
  assign sub_slice = state_ff.sub_slice;
  assign sub_index = state_ff.sub_index;
  assign sub_wr = state_ff.sub_wr;
  assign sub_rd = state_ff.sub_rd;
  assign sub_wdata = state_ff.sub_wdata;
endmodule
